//--- rtl/ifgs_sequencer.sv
// top of the input fault gate sequencer
`include "ifgs_params.svh"
module ifgs_sequencer
    import ifgs_pkg::*;
#(
    parameter int START_CYCLES = `IFGS_START_CYCLES,
    parameter int BLANK_CYCLES = `IFGS_BLANK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // comparator and control pins
    input wire logic lowInputLockout,
    input wire logic highInputLockout,
    input wire logic inputBelowGround,
    input wire logic shutdownReq,
    // gate drives
    output logic nfetGateDrive,
    output logic chargePumpEnable,
    output logic pfetGateDrive,
    // open-drain fault flag, oe high while driving low
    output logic faultFlagOut,
    output logic faultFlagOe,
    // state view
    output logic inOnState,
    output logic inShutdown
);

    // raw and synchronised pin levels, one bit per pin
    wire logic [`IFGS_PIN_COUNT-1:0] pinRaw;
    logic [`IFGS_PIN_COUNT-1:0] pinSync;
    // sequencer state and the shared wait and blanking counter
    ifgs_state_type state_q;
    ifgs_state_type state_d;
    logic [`IFGS_CNT_W-1:0] count_q;
    logic [`IFGS_CNT_W-1:0] count_d;
    // registered drive levels and their next values
    logic nGate_q;
    logic nGate_d;
    logic pGate_q;
    logic pGate_d;
    logic flagLow_q;
    logic flagLow_d;
    // registered state view and its next values
    logic onState_q;
    logic onState_d;
    logic shut_q;
    logic shut_d;

    // n-gate and charge pump run from the start of blanking onwards
    function automatic logic gateOn(input ifgs_state_type s);
        gateOn = (s == IFGS_BLANK) || (s == IFGS_ON);
    endfunction : gateOn

    // only the on state pulls the flag pin low
    function automatic logic isOn(input ifgs_state_type s);
        isOn = (s == IFGS_ON);
    endfunction : isOn

    // shutdown disables every drive and ignores faults
    function automatic logic isShut(input ifgs_state_type s);
        isShut = (s == IFGS_SHUTDOWN);
    endfunction : isShut

    // gather the pins by field position before the synchroniser
    assign pinRaw[`IFGS_PIN_LOW] = lowInputLockout;
    assign pinRaw[`IFGS_PIN_HIGH] = highInputLockout;
    assign pinRaw[`IFGS_PIN_BELOW] = inputBelowGround;
    assign pinRaw[`IFGS_PIN_SHUT] = shutdownReq;

    // pins are asynchronous, so two flops come before any decode
    ifgs_sync #(
        .WIDTH(`IFGS_PIN_COUNT)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .asyncIn(pinRaw),
        .syncOut(pinSync)
    );

    // decoded input conditions
    wire logic lowSeen = pinSync[`IFGS_PIN_LOW];
    wire logic highSeen = pinSync[`IFGS_PIN_HIGH];
    wire logic belowGnd = pinSync[`IFGS_PIN_BELOW];
    wire logic shutSeen = pinSync[`IFGS_PIN_SHUT]; // low normally
    wire logic faultSeen = lowSeen | highSeen;

    // counter end points; a span of n cycles ends at a count of n-1
    wire logic [`IFGS_CNT_W-1:0] startLast =
        `IFGS_CNT_W'(START_CYCLES - 1);
    wire logic [`IFGS_CNT_W-1:0] blankLast =
        `IFGS_CNT_W'(BLANK_CYCLES - 1);
    wire logic startDone = (count_q == startLast);
    wire logic blankDone = (count_q == blankLast);
    wire logic [`IFGS_CNT_W-1:0] countInc = count_q + `IFGS_CNT_ONE;

    // next state and counter; the counter restarts on every state move
    always_comb begin
        state_d = state_q;
        count_d = `IFGS_CNT_ZERO;
        unique case (state_q)
            IFGS_LOCKOUT: begin
                // leave as soon as both comparators read in range
                if (!faultSeen) begin
                    state_d = IFGS_WAIT;
                end
            end
            IFGS_WAIT: begin
                if (startDone) begin
                    state_d = IFGS_BLANK;
                end else begin
                    count_d = countInc;
                end
            end
            IFGS_BLANK: begin
                if (blankDone) begin
                    state_d = IFGS_ON;
                end else begin
                    count_d = countInc;
                end
            end
            IFGS_ON: begin
                state_d = IFGS_ON;
            end
            IFGS_SHUTDOWN: begin
                // back through lockout, so the full turn-on runs again
                if (!shutSeen) begin
                    state_d = IFGS_LOCKOUT;
                end
            end
        endcase
        // shutdown first, then faults; both clear the counter
        if (shutSeen) begin
            state_d = IFGS_SHUTDOWN;
            count_d = `IFGS_CNT_ZERO;
        end else if (faultSeen && !isShut(state_q)) begin
            state_d = IFGS_LOCKOUT;
            count_d = `IFGS_CNT_ZERO;
        end
    end

    // drive levels follow the next state, so a fault cuts the n-gate, pump and flag pull-down at once
    assign nGate_d = gateOn(state_d);
    assign pGate_d = !belowGnd && !isShut(state_d);
    assign flagLow_d = isOn(state_d);
    assign onState_d = isOn(state_d);
    assign shut_d = isShut(state_d);

    // state register
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= IFGS_LOCKOUT;
        end else begin
            state_q <= state_d;
        end
    end

    // wait and blanking counter
    always_ff @(posedge clock) begin
        if (rst) begin
            count_q <= `IFGS_CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // n-gate and charge pump level, off through reset
    always_ff @(posedge clock) begin
        if (rst) begin
            nGate_q <= `IFGS_DRIVE_OFF;
        end else begin
            nGate_q <= nGate_d;
        end
    end

    // p-gate level, off through reset
    always_ff @(posedge clock) begin
        if (rst) begin
            pGate_q <= `IFGS_DRIVE_OFF;
        end else begin
            pGate_q <= pGate_d;
        end
    end

    // flag pull-down, released through reset so the flag reads asserted
    always_ff @(posedge clock) begin
        if (rst) begin
            flagLow_q <= `IFGS_DRIVE_OFF;
        end else begin
            flagLow_q <= flagLow_d;
        end
    end

    // state view for the host
    always_ff @(posedge clock) begin
        if (rst) begin
            onState_q <= `IFGS_DRIVE_OFF;
            shut_q <= `IFGS_DRIVE_OFF;
        end else begin
            onState_q <= onState_d;
            shut_q <= shut_d;
        end
    end

    // pin outputs; a released flag pin is pulled high on the host side
    assign nfetGateDrive = nGate_q;
    assign chargePumpEnable = nGate_q;
    assign pfetGateDrive = pGate_q;
    assign faultFlagOut = `IFGS_FLAG_LOW; // open drain only sinks
    assign faultFlagOe = flagLow_q;
    assign inOnState = onState_q;
    assign inShutdown = shut_q;
endmodule : ifgs_sequencer

//--- rtl/ifgs_params.svh
// timing constants and field values for the input fault gate sequencer
`ifndef IFGS_PARAMS_SVH
`define IFGS_PARAMS_SVH
`define IFGS_CLOCK_MHZ 200
`define IFGS_START_WAIT_MS 50
`define IFGS_BLANK_MS 50
`define IFGS_CYCLES_PER_MS (`IFGS_CLOCK_MHZ * 1000)
`define IFGS_START_CYCLES (`IFGS_START_WAIT_MS * `IFGS_CYCLES_PER_MS)
`define IFGS_BLANK_CYCLES (`IFGS_BLANK_MS * `IFGS_CYCLES_PER_MS)
`define IFGS_CNT_W 24
`define IFGS_CNT_ZERO 24'h00_0000
`define IFGS_CNT_ONE 24'h00_0001
`define IFGS_PIN_COUNT 4
`define IFGS_PIN_LOW 0
`define IFGS_PIN_HIGH 1
`define IFGS_PIN_BELOW 2
`define IFGS_PIN_SHUT 3
`define IFGS_SYNC_IDLE 1'h0
`define IFGS_DRIVE_OFF 1'h0
`define IFGS_FLAG_LOW 1'h0
`endif

//--- rtl/ifgs_pkg.sv
// types for the input fault gate sequencer
package ifgs_pkg;
    typedef enum logic [2:0] {
        IFGS_LOCKOUT,
        IFGS_WAIT,
        IFGS_BLANK,
        IFGS_ON,
        IFGS_SHUTDOWN
    } ifgs_state_type;
endpackage : ifgs_pkg

//--- rtl/ifgs_sync.sv
// two flop synchroniser bank for the pin inputs
`include "ifgs_params.svh"
module ifgs_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // async in, synced out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // two stages per bit, first stage read only by the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (rst) begin
                    stage1_q[i] <= `IFGS_SYNC_IDLE;
                    stage2_q[i] <= `IFGS_SYNC_IDLE;
                end else begin
                    stage1_q[i] <= asyncIn[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate

    assign syncOut = stage2_q;
endmodule : ifgs_sync

//--- testbench/ifgs_checker_sva.sv
// port checker for the sequencer
`include "ifgs_params.svh"
module ifgs_checker_sva
    import ifgs_pkg::*;
#(
    parameter int BLANK_CYCLES = `IFGS_BLANK_CYCLES
) (
    // clock, reset
    input wire logic clock,
    input wire logic rst,
    // pins
    input wire logic lowInputLockout,
    input wire logic highInputLockout,
    input wire logic inputBelowGround,
    input wire logic shutdownReq,
    // drives
    input wire logic nfetGateDrive,
    input wire logic chargePumpEnable,
    input wire logic pfetGateDrive,
    input wire logic faultFlagOut,
    input wire logic faultFlagOe,
    input wire logic inOnState,
    input wire logic inShutdown
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // cycles the n-gate has been on
    logic [23:0] dwell_q;
    wire logic [23:0] dwell_d =
        nfetGateDrive ? dwell_q + 24'h00_0001 : 24'h00_0000;
    always_ff @(posedge clock) begin
        dwell_q <= rst ? 24'h00_0000 : dwell_d;
    end
    AST_PUMP: assert property (nfetGateDrive == chargePumpEnable)
        else $error("pump");
    AST_OVER: assert property (highInputLockout [*4] |->
        !nfetGateDrive && !faultFlagOe) else $error("over");
    AST_NOTOVER: assert property (nfetGateDrive |->
        !$past(highInputLockout, 3)) else $error("gate on");
    AST_LOW: assert property (lowInputLockout [*4] |->
        !nfetGateDrive && !faultFlagOe) else $error("low");
    AST_SHDN: assert property (shutdownReq [*4] |-> inShutdown &&
        !nfetGateDrive && !pfetGateDrive && !faultFlagOe) else $error("shdn");
    AST_ON: assert property (inOnState |-> faultFlagOe && nfetGateDrive)
        else $error("on");
    AST_PGATE: assert property (inputBelowGround [*4] |->
        !pfetGateDrive) else $error("pgate");
    AST_BLANK: assert property ($rose(faultFlagOe) |->
        dwell_q == 24'(BLANK_CYCLES)) else $error("blank");
endmodule : ifgs_checker_sva
bind ifgs_sequencer ifgs_checker_sva #(
    .BLANK_CYCLES(BLANK_CYCLES)
) chk (
    .clock(clock),
    .rst(rst),
    .lowInputLockout(lowInputLockout),
    .highInputLockout(highInputLockout),
    .inputBelowGround(inputBelowGround),
    .shutdownReq(shutdownReq),
    .nfetGateDrive(nfetGateDrive),
    .chargePumpEnable(chargePumpEnable),
    .pfetGateDrive(pfetGateDrive),
    .faultFlagOut(faultFlagOut),
    .faultFlagOe(faultFlagOe),
    .inOnState(inOnState),
    .inShutdown(inShutdown)
);

//--- testbench/ifgs_host_model.sv
// host view of the open-drain fault flag
module ifgs_host_model (
    // flag pin
    input wire logic faultFlagOut,
    input wire logic faultFlagOe,
    // level seen
    output logic flagLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up wins when released
    assign flagLevel = faultFlagOe ? faultFlagOut : 1'b1;
endmodule : ifgs_host_model

//--- testbench/ifgs_sequencer_tb.sv
// bench for the input fault gate sequencer
module ifgs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 20;
    logic clock = 0, rst = 1, lo = 0, hi = 0, bg = 0;
    logic sd = 0;
    logic ng, cp, pg, fo, oe, on, sh, flag;
    logic [7:0] n;
    int failures = 0, num_checks = 0, cyc = 0;
    initial forever #2.5 clock = ~clock;
    ifgs_sequencer #(.START_CYCLES(T), .BLANK_CYCLES(T)) dut (.clock(clock),
        .rst(rst), .lowInputLockout(lo), .highInputLockout(hi),
        .inputBelowGround(bg), .shutdownReq(sd), .nfetGateDrive(ng),
        .chargePumpEnable(cp), .pfetGateDrive(pg), .faultFlagOut(fo),
        .faultFlagOe(oe), .inOnState(on), .inShutdown(sh));
    ifgs_host_model host (.faultFlagOut(fo), .faultFlagOe(oe),
        .flagLevel(flag));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %h %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // set pins {low, high, below, shutdown}, then wait k cycles
    task automatic pins(input logic [3:0] v, input int k);
        @(posedge clock);
        {lo, hi, bg, sd} <= v;
        repeat (k) @(posedge clock);
        #1;
    endtask : pins
    // cycles until n-gate (g) or flag pull-down enable oe (!g) rises
    task automatic rise(input bit g, output logic [7:0] c);
        c = 0;
        while ((g ? ng : oe) !== 1'b1 && c < 8'hc8) begin
            @(posedge clock);
            #1;
            c++;
        end
    endtask : rise
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 0;
        rise(1, n);
        check(8'(n >= T && n < T + 8), 8'h01);
        check(8'(flag), 8'h01);
        rise(0, n);
        check(8'(n >= T - 1 && n < T + 4), 8'h01);
        check({3'h0, ng, cp, pg, flag, on}, 8'h1d);
        pins(4'b0100, 5);
        check({6'h0, ng, flag}, 8'h01);
        pins(4'b0000, 0);
        rise(1, n);
        check(8'(n >= T && n < T + 8), 8'h01);
        pins(4'b1000, 5);
        check({5'h0, ng, cp, flag}, 8'h01);
        pins(4'b0000, 0);
        rise(1, n);
        check(8'(n >= T && n < T + 8), 8'h01);
        rise(0, n);
        check(8'(n >= T - 1 && n < T + 4), 8'h01);
        pins(4'b0010, 5);
        check(8'(pg), 8'h00);
        pins(4'b0001, 5);
        check({4'h0, sh, ng, pg, flag}, 8'h09);
        check(8'(fo), 8'h00);
        pins(4'b0000, 0);
        rise(1, n);
        check(8'(n >= T && n < T + 8), 8'h01);
        check({6'h0, ng, pg}, 8'h03);
        end_sim();
    end
endmodule : ifgs_sequencer_tb
